// file: hw/rf_pll_lock_indication.sv
// lock indication, pin routing, calibration result and test register
//
// Summary of operation
// - the raw detector may toggle while locked, so a falling level alone never drops lock.
// - a rising detector edge or a steady high level marks the synthesizer as locked.
// - lock is dropped only when the detector stays low continuously for the hold time.
// - a pin select of 0x0A drives the detector output onto the general output pin.
// - the calibration result reads other than 0x3F when locked and 0x3F when not.
// - the test configuration register loses its contents during sleep.
`timescale 1ns/1ns
module rf_pll_lock_indication
    import lock_ind_pkg::*;
#(
    parameter int LOW_HOLD = `LOW_HOLD_CYCLES
)
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic lock_detect_i,
    input wire logic [`PIN_SEL_W-1:0] output_pin_select_field_i,
    input wire logic alt_pin_level_i,
    input wire logic [`CAL_W-1:0] cal_value_i,
    input wire logic cal_done_i,
    input wire logic sleep_i,
    input wire logic test_wr_i,
    input wire logic [`TEST_W-1:0] test_wdata_i,
    output logic general_output_pin_o,
    output logic packet_status_lock_o,
    output logic pll_locked_o,
    output logic [`CAL_W-1:0] synth_cal_result_reg_o,
    output logic [`TEST_W-1:0] test_config_reg_o
);
    typedef struct packed
    {
        lock_state_e state;
        logic det_d;
        logic pin;
        logic pstat;
        logic locked;
        logic [`CAL_W-1:0] cal;
        logic [`CAL_W-1:0] cal_seen;
        logic [`TEST_W-1:0] test;
    } top_s;
    top_s st_r;
    top_s st_nxt;
    logic held_low;

    ////////////////////////////////////////////////////////////////////////
    // one select decode, shared by the pin and the status bit
    function automatic logic routes_lock
    (
        input logic [`PIN_SEL_W-1:0] sel
    );
        return sel == `PIN_SEL_LOCK;
    endfunction

    // a rise counts even straight after a short low
    function automatic logic rose
    (
        input logic now_v,
        input logic before_v
    );
        return now_v && !before_v;
    endfunction

    // a captured 0x3F would read as unlocked, so a locked view shows 0 instead
    function automatic logic [`CAL_W-1:0] cal_view
    (
        input logic locked,
        input logic [`CAL_W-1:0] seen
    );
        logic [`CAL_W-1:0] v;
        if (!locked)
        begin
            v = `CAL_UNLOCKED;
        end
        else if (seen != `CAL_UNLOCKED)
        begin
            v = seen;
        end
        else
        begin
            v = '0;
        end
        return v;
    endfunction

    // sleep wins over a write, so nothing survives the sleep
    function automatic logic [`TEST_W-1:0] test_next
    (
        input logic [`TEST_W-1:0] cur,
        input logic sleep,
        input logic wr,
        input logic [`TEST_W-1:0] wdata
    );
        logic [`TEST_W-1:0] v;
        if (sleep)
        begin
            v = `TEST_RESET;
        end
        else if (wr)
        begin
            v = wdata;
        end
        else
        begin
            v = cur;
        end
        return v;
    endfunction

    // lock filter: rise or steady high locks, only a long low unlocks
    function automatic lock_state_e next_lock
    (
        input lock_state_e cur,
        input logic det,
        input logic det_prev,
        input logic held
    );
        lock_state_e n;
        n = cur;
        case (cur)
            ST_UNLOCKED:
            begin
                if (det)
                begin
                    n = ST_LOCKED;
                end
            end
            ST_LOCKED:
            begin
                // toggles are expected while locked; a fall only starts a wait
                if (!det)
                begin
                    n = ST_LOW_WAIT;
                end
            end
            ST_LOW_WAIT:
            begin
                if (rose(det, det_prev))
                begin
                    n = ST_LOCKED;
                end
                else if (held)
                begin
                    n = ST_UNLOCKED;
                end
            end
            default:
            begin
                n = ST_UNLOCKED;
            end
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    low_hold_timer #(.HOLD(LOW_HOLD)) u_low_timer
    (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .level_i(lock_detect_i),
        .held_low_o(held_low)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.det_d = lock_detect_i;
        st_nxt.state = next_lock(st_r.state, lock_detect_i, st_r.det_d, held_low);
        st_nxt.locked = (st_nxt.state != ST_UNLOCKED);

        // with select 0x0A the pin and status bit carry the raw detector, which may toggle; otherwise pin takes alt_pin_level_i and status 0
        if (routes_lock(output_pin_select_field_i))
        begin
            st_nxt.pin = lock_detect_i;
            st_nxt.pstat = lock_detect_i;
        end
        else
        begin
            st_nxt.pin = alt_pin_level_i;
            st_nxt.pstat = 1'b0;
        end

        // calibration result reflects the filtered lock state
        if (cal_done_i)
        begin
            st_nxt.cal_seen = cal_value_i;
        end
        st_nxt.cal = cal_view(st_nxt.locked, st_nxt.cal_seen);

        // contents are lost in sleep; host must rewrite afterwards
        st_nxt.test = test_next(st_r.test, sleep_i, test_wr_i, test_wdata_i);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= '{state: ST_UNLOCKED, det_d: 1'b0, pin: 1'b0, pstat: 1'b0,
                      locked: 1'b0, cal: `CAL_RESET, cal_seen: `CAL_RESET,
                      test: `TEST_RESET};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign general_output_pin_o = st_r.pin;
    assign packet_status_lock_o = st_r.pstat;
    assign pll_locked_o = st_r.locked;
    assign synth_cal_result_reg_o = st_r.cal;
    assign test_config_reg_o = st_r.test;
endmodule // rf_pll_lock_indication

// file: include/lock_ind_cfg.svh
// constants for the synthesizer lock indication block
`ifndef LOCK_IND_CFG_SVH
`define LOCK_IND_CFG_SVH
`define PIN_SEL_W 6
`define PIN_SEL_LOCK 6'h0A
`define CAL_W 6
`define CAL_UNLOCKED 6'h3F
`define CAL_RESET 6'h3F
`define TEST_W 8
`define TEST_RESET 8'h00
`define LOW_HOLD_CYCLES 16
`define CNT_W 8
`endif

// file: include/lock_ind_pkg.sv
// types for the synthesizer lock indication block
`include "lock_ind_cfg.svh"
package lock_ind_pkg;
    typedef enum logic [1:0] {ST_UNLOCKED, ST_LOCKED, ST_LOW_WAIT} lock_state_e;
    typedef logic [`CNT_W-1:0] count_t;
endpackage

// file: hw/low_hold_timer.sv
// counter that reports a level held low for a number of cycles
`timescale 1ns/1ns
module low_hold_timer
    import lock_ind_pkg::*;
#(
    parameter int HOLD = `LOW_HOLD_CYCLES
)
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic level_i,
    output logic held_low_o
);
    typedef struct packed
    {
        count_t cnt;
        logic held;
    } timer_s;
    timer_s st_r;
    timer_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (level_i)
        begin
            st_nxt.cnt = '0;
            st_nxt.held = 1'b0;
        end
        else if (st_r.cnt < count_t'(HOLD - 1))
        begin
            st_nxt.cnt = st_r.cnt + count_t'(1);
        end
        else
        begin
            st_nxt.held = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign held_low_o = st_r.held;
endmodule // low_hold_timer

// file: dv/lock_ind_properties.sv
// checker for the lock indication block
`timescale 1ns/1ns
module lock_ind_properties
    import lock_ind_pkg::*;
#(parameter int LOW_HOLD = `LOW_HOLD_CYCLES)
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic lock_detect_i,
    input wire logic [`PIN_SEL_W-1:0] output_pin_select_field_i,
    input wire logic sleep_i,
    input wire logic general_output_pin_o,
    input wire logic packet_status_lock_o,
    input wire logic pll_locked_o,
    input wire logic [`CAL_W-1:0] synth_cal_result_reg_o,
    input wire logic [`TEST_W-1:0] test_config_reg_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire logic sel = output_pin_select_field_i == `PIN_SEL_LOCK;
    // counter, since the hold is a parameter
    int lows;
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            lows <= 0;
        else if (lock_detect_i)
            lows <= 0;
        else
            lows <= lows + 1;
    end
    sequence det_fall_locked;
        pll_locked_o && $fell(lock_detect_i);
    endsequence
    ////////////////////
    chk_pin_route: assert property (sel |=> general_output_pin_o == $past(lock_detect_i))
        else $error("pin");
    chk_stat_copy: assert property (sel |=> packet_status_lock_o == $past(lock_detect_i))
        else $error("status");
    chk_lock_rise: assert property (lock_detect_i |=> pll_locked_o) else $error("rise");
    chk_glitch_hold: assert property (det_fall_locked |=> pll_locked_o)
        else $error("glitch");
    chk_drop_late: assert property ($fell(pll_locked_o) |-> lows >= LOW_HOLD)
        else $error("early");
    chk_drop_bound: assert property (lows >= LOW_HOLD + 4 |-> !pll_locked_o)
        else $error("late");
    chk_cal_code: assert property (pll_locked_o !=
        (synth_cal_result_reg_o == `CAL_UNLOCKED)) else $error("cal");
    chk_sleep_clear: assert property (sleep_i |=> test_config_reg_o == `TEST_RESET)
        else $error("sleep");
endmodule // lock_ind_properties
bind rf_pll_lock_indication lock_ind_properties #(.LOW_HOLD(LOW_HOLD)) chk_u (.*);

// file: dv/host_model.sv
// host model: sleep, test register restore, lock interrupt
`timescale 1ns/1ns
module host_model
(
    input wire logic clk_sys_i,
    input wire logic sleep_req_i,
    input wire logic pin_i,
    output logic sleep_o = 0,
    output logic test_wr_o = 0,
    output int irqs_o = 0
);
    logic pin_r = 0;
    // lock taken from the pin edge only, never by polling status
    always @(posedge clk_sys_i)
    begin
        sleep_o <= sleep_req_i;
        test_wr_o <= sleep_o && !sleep_req_i;
        pin_r <= pin_i;
        if (pin_i && !pin_r && !sleep_o && !sleep_req_i)
            irqs_o <= irqs_o + 1;
    end
endmodule // host_model

// file: dv/test_rf_pll_lock_indication.sv
// bench for the lock indication block
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module test_rf_pll_lock_indication;
    logic clk_sys_i = 0, reset_n_i = 0, det = 0, alt = 0, cal_done = 0, slp = 0;
    logic sleep, twr, pin, st, lk;
    logic [5:0] sel = 0, cal_v = 0, cal;
    logic [7:0] tst;
    logic [1:0] p;
    int n_mismatch = 0, total_checks = 0, seed = 32'hd1a5, cyc = 0, irq, i0;
    always #50 clk_sys_i = ~clk_sys_i;
    rf_pll_lock_indication #(.LOW_HOLD(4)) dut_u (.clk_sys_i, .reset_n_i, .lock_detect_i(det),
        .output_pin_select_field_i(sel), .alt_pin_level_i(alt), .cal_value_i(cal_v),
        .cal_done_i(cal_done), .sleep_i(sleep), .test_wr_i(twr), .test_wdata_i(8'h5A),
        .general_output_pin_o(pin), .packet_status_lock_o(st), .pll_locked_o(lk),
        .synth_cal_result_reg_o(cal), .test_config_reg_o(tst));
    host_model host_u (.clk_sys_i, .sleep_req_i(slp), .pin_i(pin), .sleep_o(sleep),
        .test_wr_o(twr), .irqs_o(irq));
    function automatic logic [1:0] route(logic [5:0] s, logic d, logic a);
        return {s == `PIN_SEL_LOCK ? d : a, s == `PIN_SEL_LOCK && d};
    endfunction
    task automatic drv(logic d, logic s, int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            det <= d;
            slp <= s;
            cal_done <= 0;
        end
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d bad %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // whole run needs about 140 cycles
    always @(posedge clk_sys_i)
        if (++cyc > 400)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    ////////////////////
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1;
        repeat (80)
        begin
            @(posedge clk_sys_i);
            p = route(sel, det, alt);
            sel <= $random(seed) % 2 ? `PIN_SEL_LOCK : 6'($random(seed));
            {det, alt} <= 2'($random(seed));
            #1 `CHK({pin, st}, p)
        end
        $display("routing done");
        @(posedge clk_sys_i);
        sel <= `PIN_SEL_LOCK;
        cal_v <= 6'h2C;
        cal_done <= 1;
        drv(1, 0, 4);
        `CHK(lk, 1'b1)
        `CHK(cal, 6'h2C)
        drv(0, 0, 2);
        `CHK(lk, 1'b1)
        drv(1, 0, 1);
        drv(0, 0, 12);
        `CHK(lk, 1'b0)
        `CHK(cal, `CAL_UNLOCKED)
        i0 = irq;
        drv(1, 0, 3);
        `CHK(lk, 1'b1)
        `CHK(irq, i0 + 1)
        $display("lock filter done");
        drv(0, 1, 3);
        drv(1, 1, 3);
        drv(1, 0, 4);
        `CHK(tst, 8'h5A)
        `CHK(irq, i0 + 1)
        drv(1, 1, 3);
        `CHK(tst, `TEST_RESET)
        $display("sleep done");
        tally_and_finish();
    end
endmodule // test_rf_pll_lock_indication
